// [common/dfrs_pkg.sv]
// Package of constants for the drive fault reaction selector.
`default_nettype none
package dfrs_pkg;
	// Register word indices; each register takes one aligned word.
	localparam logic [15:0] IDX_DEV_CODE    = 16'h3700;
	localparam logic [15:0] IDX_LIMIT_CODE  = 16'h3701;
	localparam logic [15:0] IDX_STATUS      = 16'h3702;
	localparam logic [15:0] IDX_IRQ_STAT    = 16'h3703;
	localparam logic [15:0] IDX_IRQ_MASK    = 16'h3704;
	localparam int          WORD_SHIFT      = 2;
	// Byte addresses on the APB slave are four times the index.
	localparam logic [15:0] ADDR_LIMIT_CODE = IDX_LIMIT_CODE << WORD_SHIFT;
	localparam logic [15:0] ADDR_DEV_CODE   = IDX_DEV_CODE << WORD_SHIFT;
	localparam logic [15:0] ADDR_STATUS     = IDX_STATUS << WORD_SHIFT;
	localparam logic [15:0] ADDR_IRQ_STAT   = IDX_IRQ_STAT << WORD_SHIFT;
	localparam logic [15:0] ADDR_IRQ_MASK   = IDX_IRQ_MASK << WORD_SHIFT;
	localparam logic [15:0] CODE_RESET      = 16'hFFFF;
	// Option codes as signed 16-bit values.
	localparam logic [15:0] CODE_DISCARD    = 16'hFFFE;
	localparam logic [15:0] CODE_NONE       = 16'hFFFF;
	localparam logic [15:0] CODE_OFF        = 16'h0000;
	localparam logic [15:0] CODE_SLOW_DIS   = 16'h0001;
	localparam logic [15:0] CODE_QUICK_DIS  = 16'h0002;
	localparam logic [15:0] CODE_SLOW_QSA   = 16'h0005;
	localparam logic [15:0] CODE_QUICK_QSA  = 16'h0006;
	localparam int          WARN_BIT        = 7;
	localparam int          IRQ_LIMIT       = 0;
	localparam int          IRQ_DEV         = 1;
	localparam int          IRQ_COUNT       = 2;
	// Stopping actions.
	typedef enum logic [1:0] {
		DFRS_STOP_NONE  = 2'b00,
		DFRS_STOP_OFF   = 2'b01,
		DFRS_STOP_SLOW  = 2'b10,
		DFRS_STOP_QUICK = 2'b11
	} dfrs_stop_t;
	// Target drive states after the stop.
	typedef enum logic [1:0] {
		DFRS_GOAL_KEEP = 2'b00,
		DFRS_GOAL_SOD  = 2'b01,
		DFRS_GOAL_QSA  = 2'b10
	} dfrs_goal_t;
endpackage : dfrs_pkg
`default_nettype wire

// [hw/dfrs_top.sv]
// Fault reaction selector with APB registers and interrupt.
//
// The APB register port was left to the implementer.
`default_nettype none
module dfrs_top
	import dfrs_pkg::*;
(
	// Clock and reset.
	input  wire logic                mclk,
	input  wire logic                nrst,
	// APB slave.
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [15:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Event inputs, one-cycle pulses.
	input  wire logic                limit_hit,
	input  wire logic [31:0]         limit_pos,
	input  wire logic                following_err,
	input  wire logic                slippage_err,
	// Reaction outputs towards the power stage.
	output logic                     react_valid,
	output dfrs_pkg::dfrs_stop_t     react_stop,
	output dfrs_pkg::dfrs_goal_t     react_goal,
	output logic                     react_use_qs_decel,
	output logic                     status_warning,
	output logic                     limit_pos_valid,
	output logic      [31:0]         limit_pos_rec,
	output logic                     irq
);
	import dfrs_pkg::*;

	logic [15:0] limit_code;
	logic [15:0] dev_code;
	logic [IRQ_COUNT-1:0] irq_stat;
	logic [IRQ_COUNT-1:0] irq_mask;
	logic [IRQ_COUNT-1:0] irq_event;
	logic [IRQ_COUNT-1:0] irq_clear;
	logic        dev_hit;
	logic        setup;
	logic        wr_en;
	logic        rd_en;
	logic        wr_take;
	logic        warn_clr;
	logic        sel_limit;
	logic        sel_dev;
	logic        sel_status;
	logic        sel_irq_stat;
	logic        sel_irq_mask;
	logic        addr_hit;
	logic [31:0] next_rdata;
	// Decoded reaction of each source, ready before the event comes.
	dfrs_stop_t  lim_stop;
	dfrs_goal_t  lim_goal;
	logic        lim_qs;
	dfrs_stop_t  dev_stop;
	dfrs_goal_t  dev_goal;
	logic        dev_qs;
	dfrs_stop_t  next_stop;
	dfrs_goal_t  next_goal;
	logic        next_qs;
	logic        next_valid;

	// Event sources; following and slippage share one option code.
	assign dev_hit = following_err | slippage_err;

	// Bus phases: setup prepares the answer, access commits writes.
	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = setup & ~pwrite;
	assign wr_take = wr_en & pready;

	// Address decode, one select per register word.
	assign sel_limit    = paddr == ADDR_LIMIT_CODE;
	assign sel_dev      = paddr == ADDR_DEV_CODE;
	assign sel_status   = paddr == ADDR_STATUS;
	assign sel_irq_stat = paddr == ADDR_IRQ_STAT;
	assign sel_irq_mask = paddr == ADDR_IRQ_MASK;
	assign addr_hit     = sel_limit | sel_dev | sel_status | sel_irq_stat |
		sel_irq_mask;

	// Status warning is write-one-to-clear in the access cycle.
	assign warn_clr = wr_take & sel_status & pwdata[WARN_BIT];

	// Interrupt sources in the bit order of the interrupt status register.
	always_comb begin
		irq_event            = '0;
		irq_event[IRQ_LIMIT] = limit_hit;
		irq_event[IRQ_DEV]   = dev_hit;
	end

	// Write-one-to-clear strobes for the interrupt status.
	assign irq_clear = (wr_take & sel_irq_stat) ?
		pwdata[IRQ_COUNT-1:0] : '0;

	// Single-cycle access: pready is always high in the access phase.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			// Unmapped words answer with an error and have no effect.
			pslverr <= setup & ~addr_hit;
		end
	end

	// limit code register
	// Any 16-bit value is taken; unknown codes are decoded as no stop.
	always_ff @(posedge mclk) begin
		if (!nrst)
			limit_code <= CODE_RESET;
		else if (wr_take && sel_limit)
			limit_code <= pwdata[15:0];
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			dev_code <= CODE_RESET;
		else if (wr_take && sel_dev)
			dev_code <= pwdata[15:0];
	end

	// Mask register, same bit layout as the interrupt status.
	always_ff @(posedge mclk) begin
		if (!nrst)
			irq_mask <= '0;
		else if (wr_take && sel_irq_mask)
			irq_mask <= pwdata[IRQ_COUNT-1:0];
	end

	// Read data is latched in setup so that it stands in the access cycle.
	// Unmapped words read as zero.
	always_comb begin
		next_rdata = 32'h00000000;
		if (sel_limit)
			next_rdata[15:0] = limit_code;
		if (sel_dev)
			next_rdata[15:0] = dev_code;
		if (sel_status)
			next_rdata[WARN_BIT] = status_warning;
		if (sel_irq_stat)
			next_rdata[IRQ_COUNT-1:0] = irq_stat;
		if (sel_irq_mask)
			next_rdata[IRQ_COUNT-1:0] = irq_mask;
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			prdata <= 32'h00000000;
		else if (rd_en)
			prdata <= next_rdata;
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			status_warning <= 1'b0;
		else if (limit_hit)
			status_warning <= 1'b1;
		else if (warn_clr && pready)
			status_warning <= 1'b0;
	end

	// Sticky interrupt flags, one per source.
	// A flag cleared in the cycle of a new event stays set: set wins.
	genvar g;
	generate
		for (g = 0; g < IRQ_COUNT; g++) begin : g_irq
			always_ff @(posedge mclk) begin
				if (!nrst)
					irq_stat[g] <= 1'b0;
				else if (irq_event[g])
					irq_stat[g] <= 1'b1;
				else if (irq_clear[g])
					irq_stat[g] <= 1'b0;
			end
		end
	endgenerate

	// The line lags the flags by one cycle so it comes from a flip-flop.
	always_ff @(posedge mclk) begin
		if (!nrst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat & irq_mask);
	end

	// sample code now
	// Codes are decoded every cycle; only the event cycle uses the result.
	always_comb begin
		lim_stop = DFRS_STOP_NONE;
		lim_goal = DFRS_GOAL_KEEP;
		lim_qs   = 1'b0;
		case (limit_code)
			CODE_DISCARD: begin
				lim_stop = DFRS_STOP_NONE;
			end
			CODE_NONE: begin
				lim_stop = DFRS_STOP_NONE;
			end
			CODE_OFF: begin
				lim_stop = DFRS_STOP_OFF;
				lim_goal = DFRS_GOAL_SOD;
			end
			CODE_SLOW_DIS: begin
				lim_stop = DFRS_STOP_SLOW;
				lim_goal = DFRS_GOAL_SOD;
			end
			CODE_QUICK_DIS: begin
				lim_stop = DFRS_STOP_QUICK;
				lim_goal = DFRS_GOAL_SOD;
				lim_qs   = 1'b1;
			end
			CODE_SLOW_QSA: begin
				lim_stop = DFRS_STOP_SLOW;
				lim_goal = DFRS_GOAL_QSA;
			end
			CODE_QUICK_QSA: begin
				lim_stop = DFRS_STOP_QUICK;
				lim_goal = DFRS_GOAL_QSA;
				lim_qs   = 1'b1;
			end
			default: begin
				lim_stop = DFRS_STOP_NONE;
			end
		endcase
	end

	// Codes 5 and 6 mean nothing for a deviation error.
	// They fall to the default branch and give no stop.
	always_comb begin
		dev_stop = DFRS_STOP_NONE;
		dev_goal = DFRS_GOAL_KEEP;
		dev_qs   = 1'b0;
		case (dev_code)
			CODE_NONE: begin
				dev_stop = DFRS_STOP_NONE;
			end
			CODE_OFF: begin
				dev_stop = DFRS_STOP_OFF;
				dev_goal = DFRS_GOAL_SOD;
			end
			CODE_SLOW_DIS: begin
				dev_stop = DFRS_STOP_SLOW;
			end
			CODE_QUICK_DIS: begin
				dev_stop = DFRS_STOP_QUICK;
				dev_qs   = 1'b1;
			end
			default: begin
				dev_stop = DFRS_STOP_NONE;
			end
		endcase
	end

	// Limit switch has priority: it also protects the mechanics.
	// A deviation error in the same cycle is therefore not answered.
	always_comb begin
		next_valid = limit_hit | dev_hit;
		next_stop  = DFRS_STOP_NONE;
		next_goal  = DFRS_GOAL_KEEP;
		next_qs    = 1'b0;
		if (limit_hit) begin
			next_stop = lim_stop;
			next_goal = lim_goal;
			next_qs   = lim_qs;
		end else if (dev_hit) begin
			next_stop = dev_stop;
			next_goal = dev_goal;
			next_qs   = dev_qs;
		end
	end

	// The reaction pulse stands one cycle; the power stage must latch it.
	always_ff @(posedge mclk) begin
		if (!nrst)
			react_valid <= 1'b0;
		else
			react_valid <= next_valid;
	end

	// Reaction fields stand only in the cycle of the pulse.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			react_stop         <= DFRS_STOP_NONE;
			react_goal         <= DFRS_GOAL_KEEP;
			react_use_qs_decel <= 1'b0;
		end else begin
			react_stop         <= next_stop;
			react_goal         <= next_goal;
			react_use_qs_decel <= next_qs;
		end
	end

	// position record
	// The record is kept until the next limit switch event.
	always_ff @(posedge mclk) begin
		if (!nrst)
			limit_pos_valid <= 1'b0;
		else if (limit_hit)
			limit_pos_valid <= limit_code != CODE_DISCARD;
	end

	always_ff @(posedge mclk) begin
		if (!nrst)
			limit_pos_rec <= 32'h00000000;
		else if (limit_hit && limit_code != CODE_DISCARD)
			limit_pos_rec <= limit_pos;
		else if (limit_hit)
			limit_pos_rec <= 32'h00000000;
	end
endmodule : dfrs_top
`default_nettype wire

// [test/dfrs_checker.sv]
// Port assertions for the fault reaction selector.
`default_nettype none
module dfrs_checker
	import dfrs_pkg::*;
(
	// Watched ports.
	input wire logic                 mclk,
	input wire logic                 nrst,
	input wire logic                 limit_hit,
	input wire logic [31:0]          limit_pos,
	input wire logic                 following_err,
	input wire logic                 slippage_err,
	input wire logic                 react_valid,
	input wire dfrs_pkg::dfrs_stop_t react_stop,
	input wire dfrs_pkg::dfrs_goal_t react_goal,
	input wire logic                 react_use_qs_decel,
	input wire logic                 status_warning,
	input wire logic                 limit_pos_valid,
	input wire logic [31:0]          limit_pos_rec
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic ev;
	assign ev = limit_hit | following_err | slippage_err;
	warn_set_a: assert property (limit_hit |=> status_warning)
		else $error("warning not set");
	react_time_a: assert property (ev |=> react_valid)
		else $error("no reaction pulse");
	no_spur_a: assert property (react_valid |-> $past(ev))
		else $error("stray reaction");
	pos_rec_a: assert property (limit_hit ##1 $rose(limit_pos_valid)
		|-> limit_pos_rec == $past(limit_pos)) else $error("bad position");
	qs_decel_a: assert property (react_valid
		&& react_stop == DFRS_STOP_QUICK |-> react_use_qs_decel)
		else $error("wrong deceleration");
	qsa_ramp_a: assert property (react_valid
		&& react_goal == DFRS_GOAL_QSA |-> react_stop[1])
		else $error("quick stop without ramp");
	off_sod_a: assert property (react_valid && $past(limit_hit)
		&& react_stop == DFRS_STOP_OFF |-> react_goal == DFRS_GOAL_SOD)
		else $error("power off without disable");
	dev_keep_a: assert property (react_valid && !$past(limit_hit)
		&& react_stop != DFRS_STOP_OFF |-> react_goal == DFRS_GOAL_KEEP)
		else $error("deviation goal");
	cover property (react_valid && react_goal == DFRS_GOAL_QSA);
	cover property (react_valid && react_stop == DFRS_STOP_OFF);
	cover property (limit_hit ##1 !limit_pos_valid);
endmodule : dfrs_checker
`default_nettype wire

// [test/dfrs_partner.sv]
// Power stage model that latches each reaction it is handed.
`default_nettype none
module dfrs_partner
	import dfrs_pkg::*;
(
	// Clock, reset and reaction.
	input wire logic                 mclk,
	input wire logic                 nrst,
	input wire logic                 react_valid,
	input wire dfrs_pkg::dfrs_stop_t react_stop,
	input wire dfrs_pkg::dfrs_goal_t react_goal,
	// Last command taken.
	output logic [3:0]               cmd
);
	// Only the pulse is heeded, so a missed pulse leaves a stale command.
	always_ff @(posedge mclk) begin
		if (!nrst)
			cmd <= 4'h0;
		else if (react_valid)
			cmd <= {react_stop, react_goal};
	end
endmodule : dfrs_partner
`default_nettype wire

// [test/dfrs_top_test.sv]
// Self-checking bench for the fault reaction selector.
`default_nettype none
module dfrs_top_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dfrs_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, limit_hit = 1'b0;
	logic following_err = 1'b0, slippage_err = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, limit_pos = 32'h0, rd, prdata;
	logic pready, pslverr, react_valid, react_use_qs_decel, err, irq;
	logic status_warning, limit_pos_valid;
	logic [31:0] limit_pos_rec;
	logic [3:0] cmd;
	dfrs_stop_t react_stop;
	dfrs_goal_t react_goal;
	int n_fail = 0, comparisons = 0;
	logic [15:0] lc [8] = '{16'h0000, 16'hFFFE, 16'h0001, 16'hFFFF,
		16'h0002, 16'h0005, 16'h0006, 16'h0003};
	logic [3:0] le [8] = '{4'h5, 4'h0, 4'h9, 4'h0, 4'hD, 4'hA, 4'hE, 4'h0};
	logic [15:0] dc [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h0003, 16'h0002};
	logic [3:0] de [5] = '{4'h5, 4'h0, 4'h8, 4'h0, 4'hC};
	logic qs_seen = 1'b0;
	dfrs_top DUT (.*);
	dfrs_partner PM (.*);
	always #12.5 mclk = ~mclk;
	// The deceleration flag stands one cycle, so keep it per reaction.
	always @(posedge mclk)
		if (react_valid)
			qs_seen <= react_use_qs_decel;
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge mclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			chk(32'h0, 32'h1);
			wrap_up();
		end
	endtask : apb
	task automatic pulse(input int k);
		@(posedge mclk);
		limit_hit <= (k == 0);
		following_err <= (k == 1);
		slippage_err <= (k == 2);
		limit_pos <= limit_pos + 32'h00010003;
		@(posedge mclk);
		{limit_hit, following_err, slippage_err} <= 3'b000;
		repeat (2) @(posedge mclk);
		#1;
	endtask : pulse
	initial begin
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b0, ADDR_LIMIT_CODE, 32'h0);
		chk(rd, 32'h0000FFFF);
		apb(1'b0, ADDR_DEV_CODE, 32'h0);
		chk(rd, 32'h0000FFFF);
		apb(1'b0, ADDR_IRQ_MASK + 16'h0004, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, ADDR_IRQ_MASK, 32'h3);
		for (int j = 0; j < 8; j++) begin
			apb(1'b1, ADDR_LIMIT_CODE, {16'h0000, lc[j]});
			pulse(0);
			chk({28'h0, cmd}, {28'h0, le[j]});
			chk({31'h0, status_warning}, 32'h1);
			if (j == 1) chk({31'h0, limit_pos_valid}, 32'h0);
			if (j == 3) chk(limit_pos_rec, limit_pos);
			if (j == 4 || j == 6) chk({31'h0, qs_seen}, 32'h1);
			if (j == 2 || j == 5) chk({31'h0, qs_seen}, 32'h0);
		end
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h00000080);
		apb(1'b1, ADDR_STATUS, 32'h00000080);
		apb(1'b1, ADDR_IRQ_STAT, 32'h3);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq, status_warning}, 32'h0);
		$display("test limit switch done");
		for (int j = 0; j < 5; j++) begin
			apb(1'b1, ADDR_DEV_CODE, {16'h0000, dc[j]});
			pulse(1 + j % 2);
			chk({28'h0, cmd}, {28'h0, de[j]});
			if (j == 4) chk({31'h0, qs_seen}, 32'h1);
			if (j == 2) chk({31'h0, qs_seen}, 32'h0);
		end
		chk({30'h0, irq, status_warning}, 32'h2);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		$display("test deviation done");
		wrap_up();
	end
endmodule : dfrs_top_test
bind dfrs_top dfrs_checker CHK (.*);
`default_nettype wire
